// file: logic/dosm_top.sv
`timescale 1ns/1ps
`include "dosm_map.svh"
// How it works
// - analog output equals gain times standard output plus offset times 10 V.
// - offset 100 percent is full scale; standard output spans zero to full.
// - offsets take -100.0..+100.0 percent, gains -10.00..+10.00, default 1.00.
// - pulse full-scale setting 0.01..100.00 kHz, default 50.00 kHz.
// - three digital terminals follow their input after a settable delay.
// - polarity word bit 0, bit 1 and bit 3 map the three terminals.
// - polarity 0 closes when active; polarity 1 opens when active.
// - level flags set above detection value, clear below it minus lag.
// - lag is a percentage of that flag's own detection value.
// - detection values range up to maximum frequency, default 50.00 Hz.
// - arrival flag when running frequency near target, band of max freq.
// - two frequency-reach flags within plus or minus width of value.
// - two current-reach flags within plus or minus width of level.
// - overrun flag when first analog input leaves its low..high window.
// - temperature flag once heatsink reaches threshold, default 75 C.
// - zero-current flag after current stays low longer than delay.
// - overcurrent flag after current exceeds limit longer than delay.
// - six input function selectors accept 0..60 with given defaults.
// - pulse frequency proportional to source, never below 0.01 kHz.
module dosm_top
  import dosm_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `DOSM_TICK_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [15:0] run_freq_i,
  input  wire logic [15:0] target_freq_i,
  input  wire logic [15:0] out_current_i,
  input  wire logic [15:0] ain1_i,
  input  wire logic [7:0]  heatsink_temp_i,
  input  wire logic [13:0] aout1_std_i,
  input  wire logic [13:0] aout2_std_i,
  input  wire logic [13:0] pulse_src_i,
  input  wire logic [2:0]  term_act_i,
  output logic      [13:0] analog_output_one_o,
  output logic      [13:0] analog_output_two_o,
  output logic      [13:0] pulse_freq_output_o,
  output logic             pulse_capable_digital_output_o,
  output logic             relay1_o,
  output logic             open_collector_output_o,
  output logic      [10:0] flags_o,
  output logic      [35:0] di_func_o
);

  dosm_state_s s_r;
  dosm_state_s s_nxt;
  logic        tick;

  function automatic logic [13:0] aout_calc(input logic [15:0] k,
                                            input logic [15:0] b,
                                            input logic [13:0] x);
    logic signed [31:0] y;
    y = ($signed(k) * $signed({18'h00000, x})) / `DOSM_GAIN_DIV
        + $signed(b) * `DOSM_OFS_MUL;
    if (y < 32'sh00000000) begin
      return 14'h0000;
    end else if (y > $signed({18'h00000, `DOSM_FS})) begin
      return `DOSM_FS;
    end else begin
      return y[13:0];
    end
  endfunction

  function automatic logic cfg_ok(input logic [5:0]  idx,
                                  input logic [15:0] v,
                                  input logic [15:0] maxf,
                                  input logic [15:0] lo,
                                  input logic [15:0] hi);
    logic ok;
    ok = 1'b0;
    if (idx == `DOSM_R_PULSE_FS) begin
      ok = v >= `DOSM_PULSE_MIN && v <= `DOSM_LIM_PULSE;
    end else if (idx >= `DOSM_R_AOUT1_OFS && idx <= `DOSM_R_AOUT2_GAIN) begin
      ok = $signed(v) <= $signed(`DOSM_LIM_PCT) &&
           $signed(v) >= -$signed(`DOSM_LIM_PCT);
    end else if (idx >= `DOSM_R_DLY_PCDO && idx <= `DOSM_R_DLY_OC) begin
      ok = v <= `DOSM_LIM_ODLY;
    end else if (idx == `DOSM_R_POL) begin
      ok = (v & ~`DOSM_POL_MASK) == 16'h0000;
    end else if (idx == `DOSM_R_LVF1_LVL || idx == `DOSM_R_LVF2_LVL ||
                 idx == `DOSM_R_RCH1_FRQ || idx == `DOSM_R_RCH2_FRQ) begin
      ok = v <= maxf;
    end else if (idx == `DOSM_R_LVF1_LAG || idx == `DOSM_R_LVF2_LAG ||
                 idx == `DOSM_R_ARR_BAND || idx == `DOSM_R_RCH1_WID ||
                 idx == `DOSM_R_RCH2_WID) begin
      ok = v <= `DOSM_LIM_PCT;
    end else if (idx >= `DOSM_R_CUR1_LVL && idx <= `DOSM_R_CUR2_WID) begin
      ok = v <= `DOSM_LIM_CUR;
    end else if (idx == `DOSM_R_AIN_LOW) begin
      ok = v <= hi;
    end else if (idx == `DOSM_R_AIN_HIGH) begin
      ok = v >= lo && v <= `DOSM_LIM_AIN;
    end else if (idx == `DOSM_R_TEMP_THR) begin
      ok = v <= `DOSM_LIM_TEMP;
    end else if (idx == `DOSM_R_ZERO_LVL || idx == `DOSM_R_OVER_LVL) begin
      ok = v <= `DOSM_LIM_CUR;
    end else if (idx == `DOSM_R_ZERO_DLY || idx == `DOSM_R_OVER_DLY) begin
      ok = v <= `DOSM_LIM_TDLY;
    end else if (idx == `DOSM_R_MAX_FREQ) begin
      ok = 1'b1;
    end else if (idx >= `DOSM_R_DI_FUNC && idx < `DOSM_R_STATUS) begin
      ok = v <= `DOSM_LIM_DI;
    end
    return ok;
  endfunction

  assign tick = s_r.tick_cnt == 20'(TICK_CYCLES - 1);

  always_comb begin
    logic [25:0] prod;
    logic [27:0] pprod;
    logic [15:0] thr;
    logic [15:0] diff;
    logic [15:0] wval;
    logic [15:0] lvl;
    logic [15:0] eff_lo;
    logic [5:0]  idx;
    logic        req;
    logic        mapped;
    prod   = 26'h0000000;
    pprod  = 28'h0000000;
    thr    = 16'h0000;
    diff   = 16'h0000;
    wval   = 16'h0000;
    lvl    = 16'h0000;
    eff_lo = 16'h0000;
    idx    = wb_adr_i[7:2];
    req    = wb_cyc_i && wb_stb_i && !s_r.ack;
    mapped = wb_adr_i[31:8] == 24'h000000 && wb_adr_i[1:0] == 2'b00 &&
             idx <= `DOSM_R_STATUS;
    s_nxt  = s_r;

    // Bus slave, one wait state; a write lands on the edge seeing ack
    s_nxt.ack = req;
    if (req) begin
      s_nxt.rdat = 32'h00000000;
      if (mapped && idx == `DOSM_R_STATUS) begin
        s_nxt.rdat = {18'h00000, s_r.dstate, s_r.flags};
      end else if (mapped) begin
        s_nxt.rdat = {16'h0000, s_r.cfg[idx]};
      end
    end
    if (s_r.ack && wb_cyc_i && wb_stb_i && wb_we_i && mapped &&
        idx != `DOSM_R_STATUS) begin
      wval = {wb_sel_i[1] ? wb_dat_i[15:8] : s_r.cfg[idx][15:8],
              wb_sel_i[0] ? wb_dat_i[7:0]  : s_r.cfg[idx][7:0]};
      // Out-of-range writes are dropped, old value kept
      if (cfg_ok(idx, wval, s_r.cfg[`DOSM_R_MAX_FREQ],
                 s_r.cfg[`DOSM_R_AIN_LOW], s_r.cfg[`DOSM_R_AIN_HIGH])) begin
        s_nxt.cfg[idx] = wval;
      end
    end

    // Sample tick
    s_nxt.tick_cnt = tick ? 20'h00000 : s_r.tick_cnt + 20'h00001;

    // Analog outputs follow every cycle
    s_nxt.aout1 = aout_calc(s_r.cfg[`DOSM_R_AOUT1_GAIN],
                            s_r.cfg[`DOSM_R_AOUT1_OFS], aout1_std_i);
    s_nxt.aout2 = aout_calc(s_r.cfg[`DOSM_R_AOUT2_GAIN],
                            s_r.cfg[`DOSM_R_AOUT2_OFS], aout2_std_i);

    // Pulse output, source 10000 equals full scale
    pprod = s_r.cfg[`DOSM_R_PULSE_FS][13:0] *
            (pulse_src_i > `DOSM_FS ? `DOSM_FS : pulse_src_i);
    pprod = pprod / `DOSM_SRC_DIV;
    s_nxt.pulse = pprod[13:0] < 14'(`DOSM_PULSE_MIN) ?
                  14'(`DOSM_PULSE_MIN) : pprod[13:0];

    // Terminal delays, counted in tenths of a second
    for (int n = 0; n < 3; n++) begin
      if (tick) begin
        if (term_act_i[n] == s_r.dstate[n]) begin
          s_nxt.dcnt[n] = 20'h00000;
        end else if (s_r.dcnt[n] >= 20'(s_r.cfg[`DOSM_R_DLY_PCDO + n] *
                                        `DOSM_ODLY_TICKS)) begin
          s_nxt.dstate[n] = term_act_i[n];
          s_nxt.dcnt[n]   = 20'h00000;
        end else begin
          s_nxt.dcnt[n] = s_r.dcnt[n] + 20'h00001;
        end
      end
    end
    // Output high means contact closed to common
    s_nxt.term[0] = s_r.dstate[0] ^
                    s_r.cfg[`DOSM_R_POL][`DOSM_POL_PCDO];
    s_nxt.term[1] = s_r.dstate[1] ^
                    s_r.cfg[`DOSM_R_POL][`DOSM_POL_RLY];
    s_nxt.term[2] = s_r.dstate[2] ^
                    s_r.cfg[`DOSM_R_POL][`DOSM_POL_OC];

    if (tick) begin
      // Frequency level flags with hysteresis
      for (int i = 0; i < 2; i++) begin
        lvl  = s_r.cfg[`DOSM_R_LVF1_LVL + 2 * i];
        prod = lvl * s_r.cfg[`DOSM_R_LVF1_LAG + 2 * i][9:0];
        thr  = 16'(prod / `DOSM_PCT_DIV);
        if (run_freq_i > lvl) begin
          s_nxt.flags[`DOSM_F_LVF1 + i] = 1'b1;
        end else if (run_freq_i < lvl - thr) begin
          s_nxt.flags[`DOSM_F_LVF1 + i] = 1'b0;
        end
      end

      // Frequency arrival, band taken from maximum frequency
      prod = s_r.cfg[`DOSM_R_ARR_BAND][9:0] * s_r.cfg[`DOSM_R_MAX_FREQ];
      thr  = 16'(prod / `DOSM_PCT_DIV);
      diff = run_freq_i > target_freq_i ? run_freq_i - target_freq_i
                                        : target_freq_i - run_freq_i;
      s_nxt.flags[`DOSM_F_ARRIVE] = diff <= thr;

      // Arbitrary frequency reach, width taken from maximum frequency
      for (int i = 0; i < 2; i++) begin
        lvl  = s_r.cfg[`DOSM_R_RCH1_FRQ + 2 * i];
        prod = s_r.cfg[`DOSM_R_RCH1_WID + 2 * i][9:0] *
               s_r.cfg[`DOSM_R_MAX_FREQ];
        thr  = 16'(prod / `DOSM_PCT_DIV);
        diff = run_freq_i > lvl ? run_freq_i - lvl : lvl - run_freq_i;
        s_nxt.flags[`DOSM_F_REACH1 + i] = diff <= thr;
      end

      // Current reach, level and width share the rated-current unit
      for (int i = 0; i < 2; i++) begin
        lvl  = s_r.cfg[`DOSM_R_CUR1_LVL + 2 * i];
        diff = out_current_i > lvl ? out_current_i - lvl
                                   : lvl - out_current_i;
        s_nxt.flags[`DOSM_F_CUR1 + i] =
          diff <= s_r.cfg[`DOSM_R_CUR1_LVL + 2 * i + 1];
      end

      // Guard keeps the window sane even if limits were loaded oddly
      eff_lo = s_r.cfg[`DOSM_R_AIN_LOW] > s_r.cfg[`DOSM_R_AIN_HIGH] ?
               s_r.cfg[`DOSM_R_AIN_HIGH] : s_r.cfg[`DOSM_R_AIN_LOW];
      s_nxt.flags[`DOSM_F_AIN_OVER] =
        ain1_i > s_r.cfg[`DOSM_R_AIN_HIGH] || ain1_i < eff_lo;

      s_nxt.flags[`DOSM_F_TEMP] =
        {8'h00, heatsink_temp_i} >= s_r.cfg[`DOSM_R_TEMP_THR];

      // Zero current, counter saturates rather than wrapping
      if (out_current_i <= s_r.cfg[`DOSM_R_ZERO_LVL]) begin
        if (s_r.zcnt != 16'hFFFF) begin
          s_nxt.zcnt = s_r.zcnt + 16'h0001;
        end
        s_nxt.flags[`DOSM_F_ZERO] =
          s_r.zcnt >= s_r.cfg[`DOSM_R_ZERO_DLY];
      end else begin
        s_nxt.zcnt = 16'h0000;
        s_nxt.flags[`DOSM_F_ZERO] = 1'b0;
      end

      // Overcurrent, a zero limit disables detection
      if (s_r.cfg[`DOSM_R_OVER_LVL] != 16'h0000 &&
          out_current_i > s_r.cfg[`DOSM_R_OVER_LVL]) begin
        if (s_r.ocnt != 16'hFFFF) begin
          s_nxt.ocnt = s_r.ocnt + 16'h0001;
        end
        s_nxt.flags[`DOSM_F_OVER] =
          s_r.ocnt >= s_r.cfg[`DOSM_R_OVER_DLY];
      end else begin
        s_nxt.ocnt = 16'h0000;
        s_nxt.flags[`DOSM_F_OVER] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r                             <= '0;
      s_r.cfg[`DOSM_R_PULSE_FS]       <= `DOSM_RST_PULSE_FS;
      s_r.cfg[`DOSM_R_AOUT1_GAIN]     <= `DOSM_RST_GAIN;
      s_r.cfg[`DOSM_R_AOUT2_GAIN]     <= `DOSM_RST_GAIN;
      s_r.cfg[`DOSM_R_LVF1_LVL]       <= `DOSM_RST_FREQ;
      s_r.cfg[`DOSM_R_LVF1_LAG]       <= `DOSM_RST_LAG;
      s_r.cfg[`DOSM_R_LVF2_LVL]       <= `DOSM_RST_FREQ;
      s_r.cfg[`DOSM_R_LVF2_LAG]       <= `DOSM_RST_LAG;
      s_r.cfg[`DOSM_R_RCH1_FRQ]       <= `DOSM_RST_FREQ;
      s_r.cfg[`DOSM_R_RCH2_FRQ]       <= `DOSM_RST_FREQ;
      s_r.cfg[`DOSM_R_CUR1_LVL]       <= `DOSM_RST_CUR_LVL;
      s_r.cfg[`DOSM_R_CUR1_LVL + 2]   <= `DOSM_RST_CUR_LVL;
      s_r.cfg[`DOSM_R_AIN_LOW]        <= `DOSM_RST_AIN_LOW;
      s_r.cfg[`DOSM_R_AIN_HIGH]       <= `DOSM_RST_AIN_HIGH;
      s_r.cfg[`DOSM_R_TEMP_THR]       <= `DOSM_RST_TEMP;
      s_r.cfg[`DOSM_R_ZERO_LVL]       <= `DOSM_RST_ZERO_LVL;
      s_r.cfg[`DOSM_R_ZERO_DLY]       <= `DOSM_RST_ZERO_DLY;
      s_r.cfg[`DOSM_R_OVER_LVL]       <= `DOSM_RST_OVER_LVL;
      s_r.cfg[`DOSM_R_MAX_FREQ]       <= `DOSM_RST_FREQ;
      s_r.cfg[`DOSM_R_DI_FUNC]        <= `DOSM_RST_DI1;
      s_r.cfg[`DOSM_R_DI_FUNC + 1]    <= `DOSM_RST_DI2;
      s_r.cfg[`DOSM_R_DI_FUNC + 2]    <= `DOSM_RST_DI3;
      s_r.cfg[`DOSM_R_DI_FUNC + 3]    <= `DOSM_RST_DI4;
      s_r.cfg[`DOSM_R_DI_FUNC + 4]    <= `DOSM_RST_DI5;
      s_r.cfg[`DOSM_R_DI_FUNC + 5]    <= `DOSM_RST_DI6;
      s_r.pulse                       <= 14'(`DOSM_PULSE_MIN);
    end else begin
      s_r <= s_nxt;
    end
  end

  assign wb_dat_o                       = s_r.rdat;
  assign wb_ack_o                       = s_r.ack;
  assign analog_output_one_o            = s_r.aout1;
  assign analog_output_two_o            = s_r.aout2;
  assign pulse_freq_output_o            = s_r.pulse;
  assign pulse_capable_digital_output_o = s_r.term[0];
  assign relay1_o                       = s_r.term[1];
  assign open_collector_output_o        = s_r.term[2];
  assign flags_o                        = s_r.flags;

  for (genvar d = 0; d < 6; d++) begin : g_di
    assign di_func_o[6*d +: 6] = s_r.cfg[`DOSM_R_DI_FUNC + d][5:0];
  end

  property p_aout_range;
    @(posedge clk_i) disable iff (rst_i)
    analog_output_one_o <= `DOSM_FS && analog_output_two_o <= `DOSM_FS;
  endproperty
  a_aout_range: assert property (p_aout_range)
    else $error("analog output beyond full scale");

  property p_aout_unity;
    @(posedge clk_i) disable iff (rst_i)
    s_r.cfg[`DOSM_R_AOUT1_GAIN] == `DOSM_RST_GAIN &&
    s_r.cfg[`DOSM_R_AOUT1_OFS] == 16'h0000 && aout1_std_i <= `DOSM_FS
    |=> analog_output_one_o == $past(aout1_std_i);
  endproperty
  a_aout_unity: assert property (p_aout_unity)
    else $error("unity gain output differs from standard output");

  property p_pulse_min;
    @(posedge clk_i) disable iff (rst_i)
    pulse_freq_output_o >= 14'(`DOSM_PULSE_MIN) &&
    pulse_freq_output_o <= 14'(`DOSM_LIM_PULSE);
  endproperty
  a_pulse_min: assert property (p_pulse_min)
    else $error("pulse frequency out of range");

  property p_fdt_set;
    @(posedge clk_i) disable iff (rst_i)
    tick && run_freq_i > s_r.cfg[`DOSM_R_LVF1_LVL] |=> flags_o[`DOSM_F_LVF1];
  endproperty
  a_fdt_set: assert property (p_fdt_set)
    else $error("level flag not set above detection value");

  property p_fdt_hold;
    @(posedge clk_i) disable iff (rst_i)
    tick && flags_o[`DOSM_F_LVF1] &&
    run_freq_i == s_r.cfg[`DOSM_R_LVF1_LVL] |=> flags_o[`DOSM_F_LVF1];
  endproperty
  a_fdt_hold: assert property (p_fdt_hold)
    else $error("level flag dropped inside lag band");

  property p_ain_over;
    @(posedge clk_i) disable iff (rst_i)
    tick && ain1_i > s_r.cfg[`DOSM_R_AIN_HIGH] |=> flags_o[`DOSM_F_AIN_OVER];
  endproperty
  a_ain_over: assert property (p_ain_over)
    else $error("input overrun not flagged");

  property p_temp;
    @(posedge clk_i) disable iff (rst_i)
    tick ##0 ({8'h00, heatsink_temp_i} >= s_r.cfg[`DOSM_R_TEMP_THR])
    |=> flags_o[`DOSM_F_TEMP];
  endproperty
  a_temp: assert property (p_temp)
    else $error("temperature flag missing");

  property p_zero_clear;
    @(posedge clk_i) disable iff (rst_i)
    tick && out_current_i > s_r.cfg[`DOSM_R_ZERO_LVL]
    |=> !flags_o[`DOSM_F_ZERO] && s_r.zcnt == 16'h0000;
  endproperty
  a_zero_clear: assert property (p_zero_clear)
    else $error("zero-current flag or counter not cleared");

  property p_over_off;
    @(posedge clk_i) disable iff (rst_i)
    s_r.cfg[`DOSM_R_OVER_LVL] == 16'h0000 &&
    (tick || !flags_o[`DOSM_F_OVER]) |=> !flags_o[`DOSM_F_OVER];
  endproperty
  a_over_off: assert property (p_over_off)
    else $error("overcurrent flagged while disabled");

  property p_tick_gap;
    @(posedge clk_i) disable iff (rst_i)
    tick |=> !tick [*2];
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("sample ticks too close");

endmodule

// file: logic/dosm_map.svh
`ifndef DOSM_MAP_SVH
`define DOSM_MAP_SVH

// Register indices, byte address is index times four
`define DOSM_NREG         37
`define DOSM_IDX_W        6
`define DOSM_R_PULSE_FS   6'h00
`define DOSM_R_AOUT1_OFS  6'h01
`define DOSM_R_AOUT1_GAIN 6'h02
`define DOSM_R_AOUT2_OFS  6'h03
`define DOSM_R_AOUT2_GAIN 6'h04
`define DOSM_R_DLY_PCDO   6'h05
`define DOSM_R_DLY_OC     6'h07
`define DOSM_R_POL        6'h08
`define DOSM_R_LVF1_LVL   6'h09
`define DOSM_R_LVF1_LAG   6'h0A
`define DOSM_R_LVF2_LVL   6'h0B
`define DOSM_R_LVF2_LAG   6'h0C
`define DOSM_R_ARR_BAND   6'h0D
`define DOSM_R_RCH1_FRQ   6'h0E
`define DOSM_R_RCH1_WID   6'h0F
`define DOSM_R_RCH2_FRQ   6'h10
`define DOSM_R_RCH2_WID   6'h11
`define DOSM_R_CUR1_LVL   6'h12
`define DOSM_R_CUR2_WID   6'h15
`define DOSM_R_AIN_LOW    6'h16
`define DOSM_R_AIN_HIGH   6'h17
`define DOSM_R_TEMP_THR   6'h18
`define DOSM_R_ZERO_LVL   6'h19
`define DOSM_R_ZERO_DLY   6'h1A
`define DOSM_R_OVER_LVL   6'h1B
`define DOSM_R_OVER_DLY   6'h1C
`define DOSM_R_MAX_FREQ   6'h1D
`define DOSM_R_DI_FUNC    6'h1E
`define DOSM_R_STATUS     6'h24

// Field positions
`define DOSM_POL_PCDO     0
`define DOSM_POL_RLY      1
`define DOSM_POL_OC       3
`define DOSM_POL_MASK     16'h000B
`define DOSM_F_LVF1       0
`define DOSM_F_ARRIVE     2
`define DOSM_F_REACH1     3
`define DOSM_F_CUR1       5
`define DOSM_F_AIN_OVER   7
`define DOSM_F_TEMP       8
`define DOSM_F_ZERO       9
`define DOSM_F_OVER       10
`define DOSM_NFLAG        11

// Accepted ranges
`define DOSM_LIM_PCT      16'h03E8
`define DOSM_LIM_PULSE    16'h2710
`define DOSM_PULSE_MIN    16'h0001
`define DOSM_LIM_ODLY     16'h8CA0
`define DOSM_LIM_CUR      16'h0BB8
`define DOSM_LIM_AIN      16'h03E8
`define DOSM_LIM_TEMP     16'h0064
`define DOSM_LIM_TDLY     16'hEA60
`define DOSM_LIM_DI       16'h003C

// Reset values
`define DOSM_RST_PULSE_FS 16'h1388
`define DOSM_RST_GAIN     16'h0064
`define DOSM_RST_FREQ     16'h1388
`define DOSM_RST_LAG      16'h0032
`define DOSM_RST_CUR_LVL  16'h03E8
`define DOSM_RST_AIN_LOW  16'h0136
`define DOSM_RST_AIN_HIGH 16'h02A8
`define DOSM_RST_TEMP     16'h004B
`define DOSM_RST_ZERO_LVL 16'h0032
`define DOSM_RST_ZERO_DLY 16'h000A
`define DOSM_RST_OVER_LVL 16'h07D0
`define DOSM_RST_DI1      16'h0001
`define DOSM_RST_DI2      16'h0002
`define DOSM_RST_DI3      16'h0009
`define DOSM_RST_DI4      16'h000C
`define DOSM_RST_DI5      16'h000D
`define DOSM_RST_DI6      16'h000E

// Scaling
`define DOSM_FS           14'h2710
`define DOSM_OFS_MUL      32'sh0000000A
`define DOSM_GAIN_DIV     32'sh00000064
`define DOSM_PCT_DIV      26'h00003E8
`define DOSM_SRC_DIV      28'h0002710

// Timing
`define DOSM_CLK_PERIOD_NS 10
`define DOSM_TICK_MS       10
`define DOSM_TICK_CYC ((`DOSM_TICK_MS * 1000000) / `DOSM_CLK_PERIOD_NS)
`define DOSM_ODLY_UNIT_MS  100
`define DOSM_ODLY_TICKS    (`DOSM_ODLY_UNIT_MS / `DOSM_TICK_MS)

`endif

// file: logic/dosm_pkg.sv
`include "dosm_map.svh"

package dosm_pkg;

  typedef logic [15:0] dosm_word_t;

  typedef struct packed {
    logic [`DOSM_NREG-1:0][15:0] cfg;
    logic [19:0]                 tick_cnt;
    logic                        ack;
    logic [31:0]                 rdat;
    logic [2:0]                  dstate;
    logic [2:0][19:0]            dcnt;
    logic [2:0]                  term;
    logic [15:0]                 zcnt;
    logic [15:0]                 ocnt;
    logic [`DOSM_NFLAG-1:0]      flags;
    logic [13:0]                 aout1;
    logic [13:0]                 aout2;
    logic [13:0]                 pulse;
  } dosm_state_s;

endpackage

// file: bench/dosm_load_model.sv
`timescale 1ns/1ps
module dosm_load_model (
  input  wire logic [2:0] term_i,
  output logic      [2:0] lamp_o
);
  // Lamp lit while terminal is closed; no contact bounce modelled
  assign lamp_o = term_i;
endmodule

// file: bench/drive_output_signal_monitor_tb.sv
`timescale 1ns/1ps
module drive_output_signal_monitor_tb;
  import dosm_pkg::*;
  localparam int TK = 8;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0;
  logic        we = 1'b0, ack, pcdo, rly, oc;
  logic [31:0] adr = 32'h0, dat = 32'h0, rd, dat_o;
  logic [3:0]  sel = 4'h3;
  logic [15:0] run = 16'h0, tgt = 16'h0, cur = 16'h0, ain = 16'h0;
  logic [7:0]  temp = 8'h0;
  logic [13:0] s1 = 14'h0, s2 = 14'h0, psrc = 14'h0, ao1, ao2, pf;
  logic [2:0]  act = 3'h0, lamp;
  logic [10:0] flags;
  logic [35:0] difn;
  int          error_cnt = 0, tests_run = 0;

  always #5 clk_i = ~clk_i;

  dosm_top #(.TICK_CYCLES(TK)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .run_freq_i(run),
    .target_freq_i(tgt), .out_current_i(cur), .ain1_i(ain),
    .heatsink_temp_i(temp), .aout1_std_i(s1), .aout2_std_i(s2),
    .pulse_src_i(psrc), .term_act_i(act), .analog_output_one_o(ao1),
    .analog_output_two_o(ao2), .pulse_freq_output_o(pf),
    .pulse_capable_digital_output_o(pcdo), .relay1_o(rly),
    .open_collector_output_o(oc), .flags_o(flags), .di_func_o(difn));

  dosm_load_model LOAD (.term_i({oc, rly, pcdo}), .lamp_o(lamp));

  task chk(input string n, input logic [35:0] s, e);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Holds the request until ack is sampled; bounded wait
  task bus(input logic w, input logic [7:0] i, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= {22'h0, i, 2'h0};
    dat <= {16'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    if (ack !== 1'b1) begin
      error_cnt++;
      end_sim();
    end
  endtask

  task rdc(input string n, input logic [7:0] i, input logic [15:0] e);
    bus(1'b0, i, 16'h0);
    chk(n, rd, {20'h0, e});
  endtask

  // Margin of two cycles since tick phase is not aligned to stimulus
  task tk(input int n);
    repeat (n * TK + 2) @(posedge clk_i);
  endtask

  task t_reset;
    chk("flags_rst", flags, 36'h0);
    chk("pulse_min", pf, 36'h1);
    chk("di_func", difn, {6'h0E, 6'h0D, 6'h0C, 6'h09, 6'h02, 6'h01});
    rdc("pulse_fs", 8'h00, 16'h1388);
    rdc("ao1_gain", 8'h02, 16'h0064);
    rdc("lag1_rst", 8'h0A, 16'h0032);
    rdc("temp_thr", 8'h18, 16'h004B);
    rdc("unmapped", 8'h25, 16'h0000);
    bus(1'b1, 8'h1E, 16'h003D);
    rdc("di1_refuse", 8'h1E, 16'h0001);
    bus(1'b1, 8'h1E, 16'h003C);
    rdc("di1_max", 8'h1E, 16'h003C);
  endtask

  task t_analog;
    s1 <= 14'h2710;
    s2 <= 14'h1388;
    repeat (3) @(posedge clk_i);
    chk("ao1_unity", ao1, 36'h2710);
    chk("ao2_unity", ao2, 36'h1388);
    bus(1'b1, 8'h02, 16'hFFCE);
    bus(1'b1, 8'h01, 16'h0320);
    bus(1'b1, 8'h01, 16'h03E9);
    rdc("ofs_refuse", 8'h01, 16'h0320);
    chk("ao1_full", ao1, 36'h0BB8);
    s1 <= 14'h0;
    repeat (3) @(posedge clk_i);
    chk("ao1_zero", ao1, 36'h1F40);
  endtask

  task t_pulse;
    psrc <= 14'h1388;
    repeat (3) @(posedge clk_i);
    chk("pulse_half", pf, 36'h09C4);
    bus(1'b1, 8'h00, 16'h2711);
    rdc("fs_refuse", 8'h00, 16'h1388);
    bus(1'b1, 8'h00, 16'h2710);
    repeat (3) @(posedge clk_i);
    chk("pulse_max", pf, 36'h1388);
  endtask

  task t_term;
    act <= 3'h7;
    tk(2);
    chk("closed", {oc, rly, pcdo}, 36'h7);
    chk("lamps", lamp, 36'h7);
    bus(1'b1, 8'h08, 16'h000B);
    tk(1);
    chk("inverted", {oc, rly, pcdo}, 36'h0);
    bus(1'b1, 8'h08, 16'h0000);
    bus(1'b1, 8'h05, 16'h0001);
    act <= 3'h6;
    tk(5);
    chk("held", {oc, rly, pcdo}, 36'h7);
    tk(7);
    chk("delayed", {oc, rly, pcdo}, 36'h6);
  endtask

  task t_freq;
    run <= 16'h1389;
    tgt <= 16'h1389;
    tk(1);
    chk("fdt_set", flags[1:0], 36'h3);
    chk("arrive", flags[2], 36'h1);
    chk("reach_off", flags[4:3], 36'h0);
    run <= 16'h1388;
    tk(1);
    chk("fdt_equal", flags[1:0], 36'h3);
    chk("reach_on", flags[4:2], 36'h6);
    run <= 16'h12C0;
    tk(1);
    chk("fdt_lag", flags[1:0], 36'h3);
    run <= 16'h125C;
    tk(1);
    chk("fdt_clr", flags[1:0], 36'h0);
  endtask

  task t_misc;
    bus(1'b1, 8'h1A, 16'h0002);
    cur <= 16'h03E8;
    tk(1);
    chk("cur_reach", flags[6:5], 36'h3);
    cur <= 16'h0064;
    tk(2);
    chk("zero_off", flags[9], 36'h0);
    chk("cur_leave", flags[6:5], 36'h0);
    cur <= 16'h0000;
    tk(1);
    chk("zero_wait", flags[9], 36'h0);
    tk(4);
    chk("zero_on", flags[9], 36'h1);
    cur <= 16'h0834;
    tk(1);
    chk("over_on", flags[10:9], 36'h2);
    bus(1'b1, 8'h1B, 16'h0000);
    tk(1);
    chk("over_dis", flags[10], 36'h0);
    temp <= 8'h4B;
    tk(1);
    chk("temp_on", flags[8], 36'h1);
    temp <= 8'h4A;
    ain <= 16'h01F4;
    tk(1);
    chk("temp_ain", flags[8:7], 36'h0);
    ain <= 16'h02A9;
    tk(1);
    chk("ain_high", flags[7], 36'h1);
  endtask

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_analog();
    t_pulse();
    t_term();
    t_freq();
    t_misc();
    end_sim();
  end
endmodule
